/* logic/pfh_host.sv */
// Purpose: Host-side sequencer driving an asynchronous parallel boot flash.
// Assumes: One 40 MHz clock; flash pins are asynchronous to it.
// Notes: Each request is one bus cycle, except temporary unprotect, which issues
//        none, and program, which issues the A0h command cycle and then the data cycle.
// Behaviour
// R1: Successive reads start no closer than the read cycle time of the grade.
// R2: The write strobe stays low 35 ns and then high 25 ns before another.
// R3: At least 20 ns separate a read from a write and a write from a read.
// R4: The flash may need 35 us after reset during an embedded algorithm.
// R5: The flash may need 500 ns after reset when idle.
// R6: Reset is held at least 500 ns, and reads wait 50 ns after its release.
// R7: The flash enters standby within 35 us of a held reset.
// R8: Chip select is only asserted once reset has been released.
// R9: Ready/busy goes busy within 90 ns of the final program write strobe.
// R10: Program writes A0h to 555h, then the data to the target address.
// R11: Output enable stays high at least 10 ns between status polls.
// R12: The erase-suspend toggle bit only toggles inside a suspended sector.
// R13: Protect drives address bits 3..0 as 0010, bit 6 low; unprotect high.
// R14: The elevated reset level is held 4 us before the first write.
// R15: The elevated reset level is held 4 us after ready/busy returns high.
`timescale 1ns/1ps
`default_nettype none
module pfh_host #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16,
  parameter bit FAST_GRADE = 1'b0,
  parameter int READY_CYCLES = pfh_pkg::READY_CYC,
  parameter int RSP_CYCLES = pfh_pkg::RSP_CYC,
  parameter int RRB_CYCLES = pfh_pkg::RRB_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire pfh_pkg::pfh_op_e req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_busy_algo,
  input wire logic reset_req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic flash_ready,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_vid_en,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic ready_busy_out_n
);
  localparam int CW = 24;
  localparam int RC_CYC = FAST_GRADE ? pfh_pkg::RC_FAST_CYC
                                     : pfh_pkg::RC_SLOW_CYC;

  pfh_pkg::pfh_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  logic last_wr_reg;
  logic last_poll_reg;
  logic prog_second_reg;
  logic temp_mode_reg;
  logic [DATA_W-1:0] dq_sync1_reg, dq_sync2_reg;
  logic rb_sync1_reg, rb_sync2_reg;
  pfh_pkg::pfh_op_e op_reg;

  // Asynchronous flash pins pass two flip-flops before use.
  always_ff @(posedge clk_sys) begin
    dq_sync1_reg <= flash_dq_in;
    dq_sync2_reg <= dq_sync1_reg;
    rb_sync1_reg <= ready_busy_out_n;
    rb_sync2_reg <= rb_sync1_reg;
  end

  wire logic cnt_done = (cnt_reg == '0);
  wire logic is_write_op = (req_op != pfh_pkg::PFH_OP_READ) &&
                           (req_op != pfh_pkg::PFH_OP_POLL);
  wire logic idle_accept = (state_reg == pfh_pkg::PFH_ST_IDLE) && req_valid;
  // R3 turnaround: a change of direction adds the read/write latency.
  wire logic dir_change = idle_accept && (is_write_op != last_wr_reg);
  // R13 protect pattern on bits 6 and 3..0.
  wire logic [ADDR_W-1:0] prot_addr = {req_addr[ADDR_W-1:7],
    (req_op == pfh_pkg::PFH_OP_UNPROTECT), req_addr[5:4],
    pfh_pkg::PROT_LOW_PATTERN};
  wire logic [ADDR_W-1:0] sel_addr =
    ((req_op == pfh_pkg::PFH_OP_PROTECT) ||
     (req_op == pfh_pkg::PFH_OP_UNPROTECT)) ? prot_addr : req_addr;

  assign req_ready = (state_reg == pfh_pkg::PFH_ST_IDLE) && !dir_change;
  assign flash_ready = (state_reg == pfh_pkg::PFH_ST_IDLE);

  function automatic logic [CW-1:0] c(input int n);
    return CW'(n - 1);
  endfunction : c

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pfh_pkg::PFH_ST_RESET: if (cnt_done && !reset_req) begin
        state_next = pfh_pkg::PFH_ST_RECOVER;
      end
      pfh_pkg::PFH_ST_RECOVER: if (cnt_done) begin
        state_next = pfh_pkg::PFH_ST_IDLE;
      end
      pfh_pkg::PFH_ST_IDLE: if (req_valid && !dir_change) begin
        if (req_op == pfh_pkg::PFH_OP_TEMP_UNPROT) begin
          state_next = pfh_pkg::PFH_ST_VID_SETUP;
        end else if (is_write_op) begin
          state_next = pfh_pkg::PFH_ST_WR_LO;
        end else begin
          state_next = pfh_pkg::PFH_ST_RD;
        end
      end else if (dir_change) begin
        state_next = pfh_pkg::PFH_ST_GAP;
      end
      pfh_pkg::PFH_ST_RD: if (cnt_done) begin
        state_next = pfh_pkg::PFH_ST_GAP;
      end
      pfh_pkg::PFH_ST_WR_LO: if (cnt_done) begin
        state_next = pfh_pkg::PFH_ST_WR_HI;
      end
      pfh_pkg::PFH_ST_WR_HI: if (cnt_done) begin
        state_next = prog_second_reg ? pfh_pkg::PFH_ST_WR_LO
                                     : pfh_pkg::PFH_ST_GAP;
      end
      pfh_pkg::PFH_ST_GAP: if (cnt_done) begin
        state_next = pfh_pkg::PFH_ST_IDLE;
      end
      pfh_pkg::PFH_ST_VID_SETUP: if (cnt_done) begin
        state_next = pfh_pkg::PFH_ST_VID_HOLD;
      end
      pfh_pkg::PFH_ST_VID_HOLD: if (cnt_done && rb_sync2_reg) begin
        state_next = pfh_pkg::PFH_ST_IDLE;
      end
      default: state_next = pfh_pkg::PFH_ST_RESET;
    endcase
    if (reset_req) begin
      state_next = pfh_pkg::PFH_ST_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= pfh_pkg::PFH_ST_RESET;
      // R6 reset pulse width.
      cnt_reg <= c(pfh_pkg::RP_CYC);
      last_wr_reg <= 1'b0;
      last_poll_reg <= 1'b0;
      prog_second_reg <= 1'b0;
      temp_mode_reg <= 1'b0;
      op_reg <= pfh_pkg::PFH_OP_READ;
    end else begin
      state_reg <= state_next;
      if (!cnt_done) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
      case (state_next)
        pfh_pkg::PFH_ST_RESET: if (state_reg != pfh_pkg::PFH_ST_RESET) begin
          cnt_reg <= c(pfh_pkg::RP_CYC);
          prog_second_reg <= 1'b0;
        end
        // R4 R5 R6 recovery before the first access.
        pfh_pkg::PFH_ST_RECOVER: if (state_reg == pfh_pkg::PFH_ST_RESET) begin
          cnt_reg <= req_busy_algo ? c(READY_CYCLES)
                                   : c(pfh_pkg::RP_CYC + pfh_pkg::RH_CYC);
        end
        // R1 read cycle time for reads and polls alike; R11 OE high time is added in the gap.
        pfh_pkg::PFH_ST_RD: if (state_reg == pfh_pkg::PFH_ST_IDLE) begin
          cnt_reg <= c(RC_CYC);
          last_wr_reg <= 1'b0;
          op_reg <= req_op;
        end
        // R2 low pulse; R10 command cycle first.
        pfh_pkg::PFH_ST_WR_LO: begin
          if (state_reg != pfh_pkg::PFH_ST_WR_LO) begin
            cnt_reg <= c(pfh_pkg::WP_CYC);
          end
          if (state_reg == pfh_pkg::PFH_ST_IDLE) begin
            last_wr_reg <= 1'b1;
            op_reg <= req_op;
            prog_second_reg <= (req_op == pfh_pkg::PFH_OP_PROGRAM);
          end else if (state_reg == pfh_pkg::PFH_ST_WR_HI) begin
            prog_second_reg <= 1'b0;
          end
        end
        // R2 high time before the next low pulse.
        pfh_pkg::PFH_ST_WR_HI: if (state_reg == pfh_pkg::PFH_ST_WR_LO) begin
          cnt_reg <= c(pfh_pkg::WPH_CYC);
        end
        // R3 R11 gap after reads and writes.
        pfh_pkg::PFH_ST_GAP: if (state_reg != pfh_pkg::PFH_ST_GAP) begin
          cnt_reg <= c((op_reg == pfh_pkg::PFH_OP_POLL) ?
                       pfh_pkg::OEH_CYC : pfh_pkg::SRW_CYC);
          if (state_reg == pfh_pkg::PFH_ST_IDLE) begin
            last_wr_reg <= is_write_op;
          end
        end
        // R14 elevated level setup.
        pfh_pkg::PFH_ST_VID_SETUP: if (state_reg == pfh_pkg::PFH_ST_IDLE) begin
          cnt_reg <= c(RSP_CYCLES);
          temp_mode_reg <= !temp_mode_reg;
        end
        // R15 hold after ready; the count restarts while busy.
        pfh_pkg::PFH_ST_VID_HOLD: if (!rb_sync2_reg ||
            state_reg == pfh_pkg::PFH_ST_VID_SETUP) begin
          cnt_reg <= c(RRB_CYCLES);
        end
        default: ;
      endcase
    end
  end

  // Pin registers; data outputs come from flip-flops.
  wire logic wr_low = (state_next == pfh_pkg::PFH_ST_WR_LO);
  wire logic rd_on = (state_next == pfh_pkg::PFH_ST_RD);
  wire logic rd_end = (state_reg == pfh_pkg::PFH_ST_RD) &&
                      (state_next != pfh_pkg::PFH_ST_RD);
  wire logic cmd_cycle = wr_low && (state_reg == pfh_pkg::PFH_ST_IDLE) &&
                         (req_op == pfh_pkg::PFH_OP_PROGRAM);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b0;
      flash_vid_en <= 1'b0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      flash_reset_n <= (state_next != pfh_pkg::PFH_ST_RESET);
      // R14 R15 elevated reset level while temporary unprotect is on.
      // The level must also stand through the hold after ready on exit.
      flash_vid_en <= temp_mode_reg ||
                      (state_next == pfh_pkg::PFH_ST_VID_SETUP) ||
                      (state_next == pfh_pkg::PFH_ST_VID_HOLD);
      // R8 chip select only once reset is released.
      flash_ce_n <= !(wr_low || rd_on) || (state_next ==
                    pfh_pkg::PFH_ST_RESET);
      flash_we_n <= !wr_low;
      flash_oe_n <= !rd_on;
      flash_dq_oe <= wr_low;
      rsp_valid <= rd_end;
      if (rd_end) begin
        rsp_rdata <= dq_sync2_reg;
      end
      if (state_reg == pfh_pkg::PFH_ST_IDLE && state_next !=
          pfh_pkg::PFH_ST_IDLE && state_next != pfh_pkg::PFH_ST_GAP) begin
        // R10 command cycle at 555h with A0h.
        flash_addr <= cmd_cycle ? ADDR_W'(pfh_pkg::PROG_CMD_ADDR) : sel_addr;
        flash_dq_out <= cmd_cycle ? DATA_W'(pfh_pkg::PROG_CMD_DATA)
                                  : req_wdata;
      end else if (state_reg == pfh_pkg::PFH_ST_WR_HI && wr_low) begin
        flash_addr <= req_addr;
        flash_dq_out <= req_wdata;
      end
    end
  end
endmodule : pfh_host
`default_nettype wire

/* logic/pfh_pkg.sv */
// Purpose: Constants for the parallel flash host sequencer.
// Assumes: 40 MHz system clock, 25 ns period.
// Notes: Times are kept in their printed units; cycle counts derive from them.
package pfh_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  // Minimum times round up to whole cycles.
  function automatic int cyc_min(input int t_ps);
    int c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min
  localparam int T_RC_SLOW_NS = 70;
  localparam int T_RC_FAST_NS = 55;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 25;
  localparam int T_SRW_NS = 20;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_OEH_NS = 10;
  localparam int T_RSP_US = 4;
  localparam int T_RRB_US = 4;
  localparam int T_READY_US = 35;
  localparam int RC_SLOW_CYC = cyc_min(T_RC_SLOW_NS * 1000);
  localparam int RC_FAST_CYC = cyc_min(T_RC_FAST_NS * 1000);
  localparam int WP_CYC = cyc_min(T_WP_NS * 1000);
  localparam int WPH_CYC = cyc_min(T_WPH_NS * 1000);
  localparam int SRW_CYC = cyc_min(T_SRW_NS * 1000);
  localparam int RP_CYC = cyc_min(T_RP_NS * 1000);
  localparam int RH_CYC = cyc_min(T_RH_NS * 1000);
  localparam int OEH_CYC = cyc_min(T_OEH_NS * 1000);
  localparam int RSP_CYC = cyc_min(T_RSP_US * 1000000);
  localparam int RRB_CYC = cyc_min(T_RRB_US * 1000000);
  localparam int READY_CYC = cyc_min(T_READY_US * 1000000);
  localparam logic [11:0] PROG_CMD_ADDR = 12'h555;
  localparam logic [7:0] PROG_CMD_DATA = 8'hA0;
  // Address pattern for sector-group protect and unprotect.
  localparam int PROT_SEL_BIT = 6;
  localparam logic [3:0] PROT_LOW_PATTERN = 4'h2;
  typedef enum logic [2:0] {
    PFH_OP_READ, PFH_OP_WRITE, PFH_OP_PROGRAM, PFH_OP_POLL,
    PFH_OP_PROTECT, PFH_OP_UNPROTECT, PFH_OP_TEMP_UNPROT
  } pfh_op_e;
  typedef enum logic [3:0] {
    PFH_ST_RESET, PFH_ST_RECOVER, PFH_ST_IDLE, PFH_ST_RD, PFH_ST_WR_LO,
    PFH_ST_WR_HI, PFH_ST_GAP, PFH_ST_VID_SETUP, PFH_ST_VID_HOLD
  } pfh_state_e;
endpackage : pfh_pkg

/* tb/pfh_flash_model.sv */
// Purpose: Behavioural flash device for the host sequencer bench.
// Assumes: Pins are sampled on the bench clock; sixteen words of storage.
// Notes: Released data lines show the inverse of the last value read.
`timescale 1ns/1ps
`default_nettype none
module pfh_flash_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic [20:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic [15:0] flash_dq_out,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_out_n
);
  logic [15:0] mem [16];
  logic [15:0] d_q, last = 16'h0000;
  logic [20:0] a_q;
  logic we_d, oe_d, armed = 1'b0, tog = 1'b0;
  int busy = 0;
  always @(posedge clk_sys) begin
    we_d <= flash_we_n;
    oe_d <= flash_oe_n;
    if (!flash_we_n) {a_q, d_q} <= {flash_addr, flash_dq_out};
    if (!flash_ce_n && !flash_oe_n) last <= flash_dq_in;
    if (flash_oe_n && !oe_d) tog <= !tog;
    if (!flash_reset_n) {busy, armed} <= '0;
    else if (busy > 0) busy <= busy - 1;
    else if (flash_we_n && !we_d) begin
      if (armed) mem[a_q[3:0]] <= d_q;
      if (armed) busy <= BUSY_CYC;
      armed <= !armed && a_q[11:0] == 12'h555 && d_q[7:0] == 8'hA0;
    end
  end
  assign ready_busy_out_n = (busy == 0);
  assign flash_dq_in = (flash_ce_n || flash_oe_n) ? ~last
    : (busy > 0) ? {9'h000, tog, 6'h00} : mem[flash_addr[3:0]];
endmodule : pfh_flash_model
`default_nettype wire

/* tb/pfh_host_monitor.sv */
// Purpose: Port-level timing checks for the parallel flash host sequencer.
// Assumes: One clock domain; srst is synchronous and active high.
// Notes: Bound into every pfh_host instance.
`timescale 1ns/1ps
`default_nettype none
module pfh_host_mon #(
  parameter int ADDR_W = 21,
  parameter int RSP_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pfh_pkg::pfh_op_e req_op,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic flash_vid_en,
  input wire logic flash_dq_oe
);
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [11:0] vid_reg;
  // Counters saturate so a long idle stretch never wraps to a small count.
  always_ff @(posedge clk_sys) begin
    lo_reg <= flash_reset_n ? 8'h00
      : srst ? 8'h01 : lo_reg + 8'(lo_reg != 8'hFF);
    hi_reg <= (srst || !flash_reset_n) ? 8'h00
      : hi_reg + 8'(hi_reg != 8'hFF);
    vid_reg <= (srst || !flash_vid_en) ? 12'h000
      : vid_reg + 12'(vid_reg != 12'hFFF);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_ce_in_reset: assert property (
    !flash_reset_n |-> flash_ce_n) else $error("chip select during reset");
  a_reset_width: assert property (
    $rose(flash_reset_n) |-> lo_reg >= pfh_pkg::RP_CYC)
    else $error("reset short");
  a_reset_to_read: assert property (
    $fell(flash_oe_n) |-> hi_reg >= pfh_pkg::RH_CYC)
    else $error("read too early");
  a_we_low_width: assert property (
    $fell(flash_we_n) |-> !flash_we_n [*2]) else $error("write pulse short");
  a_read_cycle_len: assert property (
    $fell(flash_oe_n) |-> !flash_oe_n [*3]) else $error("read cycle short");
  a_poll_oe_gap: assert property (
    $rose(flash_oe_n) |=> flash_oe_n) else $error("output enable gap short");
  a_read_then_write: assert property (
    $rose(flash_oe_n) |=> flash_we_n) else $error("read to write gap short");
  a_write_then_read: assert property (
    $rose(flash_we_n) |=> flash_oe_n) else $error("write to read gap short");
  a_protect_addr_bits: assert property (
    req_valid && req_ready && req_op inside {pfh_pkg::PFH_OP_PROTECT,
      pfh_pkg::PFH_OP_UNPROTECT} |-> ##[1:4] (!flash_we_n
      && flash_addr[3:0] == pfh_pkg::PROT_LOW_PATTERN && flash_addr[6] ==
      (req_op == pfh_pkg::PFH_OP_UNPROTECT)))
    else $error("protect address bad");
  a_dq_drive_write: assert property (
    !flash_we_n |-> flash_dq_oe) else $error("data not driven in write");
  a_dq_free_read: assert property (
    !flash_oe_n |-> !flash_dq_oe) else $error("data driven during read");
  a_vid_setup_time: assert property (
    flash_vid_en && $fell(flash_we_n) |-> vid_reg >= RSP_CYCLES)
    else $error("elevated level setup short");
endmodule : pfh_host_mon
bind pfh_host pfh_host_mon #(.ADDR_W(ADDR_W), .RSP_CYCLES(RSP_CYCLES)) u_mon (
  .clk_sys, .srst, .req_valid, .req_ready, .req_op, .flash_addr, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_vid_en, .flash_dq_oe);
`default_nettype wire

/* tb/pfh_host_tb.sv */
// Purpose: Self-checking bench for the parallel flash host sequencer.
// Assumes: Shortened embedded-algorithm recovery and elevated-level counts of 8 cycles.
// Notes: Random addresses and data come from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module pfh_host_tb;
  logic clk_sys, srst, req_valid, req_busy_algo, reset_req, req_ready;
  pfh_pkg::pfh_op_e req_op;
  logic [20:0] req_addr, flash_addr, a;
  logic [15:0] req_wdata, rsp_rdata, flash_dq_in, flash_dq_out, got, d;
  logic rsp_valid, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
  logic flash_vid_en, flash_dq_oe, ready_busy_out_n;
  int bad_count, checks_done;
  pfh_host #(.READY_CYCLES(8), .RSP_CYCLES(8), .RRB_CYCLES(8)) DUT (.clk_sys,
    .srst, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata,
    .req_busy_algo, .reset_req, .rsp_valid, .rsp_rdata, .flash_ready(),
    .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
    .flash_vid_en, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
    .ready_busy_out_n);
  pfh_flash_model u_flash (.clk_sys, .flash_addr, .flash_ce_n, .flash_oe_n,
    .flash_we_n, .flash_reset_n, .flash_dq_out, .flash_dq_in,
    .ready_busy_out_n);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (rsp_valid) got <= rsp_rdata;
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) bad_count++;
    if (seen !== exp) $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : chk
  // Waits for req_ready, or for the flash ready pin when rdy_pin is set.
  task automatic until_hi(input bit rdy_pin);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((rdy_pin ? ready_busy_out_n : req_ready) !== 1'b1 && n < 3000);
    if (n >= 3000) bad_count++;
    if (n >= 3000) give_verdict();
  endtask : until_hi
  task automatic op(input pfh_pkg::pfh_op_e o, input logic [20:0] ad,
                    input logic [15:0] dt);
    until_hi(0);
    {req_op, req_addr, req_wdata, req_valid} <= {o, ad, dt, 1'b1};
    req_busy_algo <= 1'($urandom);
    until_hi(0);
    req_valid <= 1'b0;
    until_hi(0);
    @(posedge clk_sys);
  endtask : op
  initial begin
    {srst, req_valid, req_busy_algo, reset_req} = 4'h8;
    {req_op, req_addr, req_wdata} = '0;
    {bad_count, checks_done} = '0;
    void'($urandom(22881));
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk(16'(flash_ce_n), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 21'h000000 : (i == 1) ? 21'h1FFFFF : 21'($urandom);
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      op(pfh_pkg::PFH_OP_WRITE, 21'($urandom), 16'($urandom));
      op(pfh_pkg::PFH_OP_PROGRAM, a, d);
      chk(16'(ready_busy_out_n), 16'h0000);
      op(pfh_pkg::PFH_OP_POLL, a, 16'h0000);
      chk(got & 16'hFFBF, 16'h0000);
      until_hi(1);
      op(pfh_pkg::PFH_OP_READ, a, 16'h0000);
      chk(got, d);
    end
    op(pfh_pkg::PFH_OP_PROGRAM, 21'h000013, 16'h1234);
    {reset_req, req_busy_algo} <= 2'h3;
    repeat (30) @(posedge clk_sys);
    reset_req <= 1'b0;
    op(pfh_pkg::PFH_OP_READ, 21'h000013, 16'h0000);
    chk(16'(ready_busy_out_n), 16'h0001);
    chk(got, 16'h1234);
    op(pfh_pkg::PFH_OP_PROTECT, 21'($urandom), 16'h0000);
    op(pfh_pkg::PFH_OP_UNPROTECT, 21'($urandom), 16'h0000);
    op(pfh_pkg::PFH_OP_TEMP_UNPROT, 21'h000000, 16'h0000);
    chk(16'(flash_vid_en), 16'h0001);
    op(pfh_pkg::PFH_OP_PROGRAM, 21'h000007, 16'hA55A);
    until_hi(1);
    op(pfh_pkg::PFH_OP_READ, 21'h000007, 16'h0000);
    chk(got, 16'hA55A);
    op(pfh_pkg::PFH_OP_TEMP_UNPROT, 21'h000000, 16'h0000);
    chk(16'(flash_vid_en), 16'h0000);
    give_verdict();
  end
endmodule : pfh_host_tb
`default_nettype wire
